// file: hw/sacc_conv_ctrl.sv
// Purpose: control of a 10-bit successive approximation converter
// Assumes: apb master on clk_sys; trigger sources on clk_sys
// Notes: prescale ratio is 4 << field, so comparator sync settles
//
// Functional notes
// - ten-bit result, zero is ground
// - reference and channel from mux fields
// - single-ended channel bypasses gain stage
// - gains 1x, 10x, 200x on pairs
// - selections apply only while enabled
// - right aligned by default, left optional
// - low read locks result bytes
// - high read unlocks result bytes
// - flag set on every completion
// - start bit high until completion, stays high when free running
// - channel change waits for conversion end
// - auto trigger uses selected source
// - trigger edge resets prescaler, starts
// - edges during conversion ignored
// - source flag must clear before retrigger
// - completion flag trigger runs continuously
// - start bit works with auto trigger
// - 13 cycles, first 25
// - prescaler held reset while disabled
// - completion writes result unless locked, sets flag
`timescale 1ns/1ns

module sacc_conv_ctrl
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system side
    input wire logic gieIn,
    input wire logic [7:0] trigSrc,
    output logic irqReq,
    // analog core
    input wire logic cmpIn,
    output sacc_pkg::sacc_ana_t anaCtrl
);
    import sacc_pkg::*;
`include "sacc_defs.svh"

    logic enable_ff, startBit_ff, auto_ff, flag_ff, irqEn_ff;
    logic [2:0] psSel_ff, trigSel_ff;
    logic [1:0] refReq_ff;
    logic leftAdj_ff, lock_ff, trigPrev_ff, first_ff;
    logic [4:0] chanReq_ff, cycCnt_ff;
    logic [9:0] res_ff;
    logic [8:0] psCnt_ff, psLimit;
    logic cmpMeta_ff, cmpSync_ff;
    sacc_state_t state_ff;
    logic setup, access, wr, rd, wrCtrl, rdHit;
    logic [31:0] rdVal;
    logic tick, done, freeRun, trigMux, trigEdge, trigStart, swStart;
    logic bitTick, sampleTick;
    logic [4:0] total, sampleAt, bitPos;
    logic [3:0] bitIdx;
    logic single;
    sacc_gain_t gainDec;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////
    // apb slave: one wait-free access cycle, data latched at setup
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr = access && pwrite;
    assign rd = access && !pwrite;
    assign wrCtrl = wr && paddr == `SACC_OFS_CTRL;

    always_comb
    begin
        rdHit = 1'b1;
        rdVal = 32'h0;
        unique case (paddr)
            `SACC_OFS_CTRL:
                rdVal[7:0] = {enable_ff, startBit_ff, auto_ff, flag_ff, irqEn_ff, psSel_ff};
            `SACC_OFS_MUX:
                rdVal[7:0] = {refReq_ff, leftAdj_ff, chanReq_ff};
            `SACC_OFS_TRIG:
                rdVal[7:0] = {trigSel_ff, 5'h00};
            `SACC_OFS_RESLO:
                rdVal[7:0] = leftAdj_ff ? {res_ff[1:0], 6'h00} : res_ff[7:0];
            `SACC_OFS_RESHI:
                rdVal[7:0] = leftAdj_ff ? res_ff[9:2] : {6'h00, res_ff[9:8]};
            default:
                rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            if (setup)
            begin
                prdata <= rdVal;
                pslverr <= !rdHit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            enable_ff <= 1'b0;
            auto_ff <= 1'b0;
            irqEn_ff <= 1'b0;
            psSel_ff <= `SACC_PS_RST;
            refReq_ff <= `SACC_REF_RST;
            leftAdj_ff <= 1'b0;
            chanReq_ff <= `SACC_CH_RST;
            trigSel_ff <= `SACC_TRIG_RST;
        end
        else
        begin
            if (wrCtrl)
            begin
                enable_ff <= pwdata[`SACC_CTRL_EN];
                auto_ff <= pwdata[`SACC_CTRL_AT];
                irqEn_ff <= pwdata[`SACC_CTRL_IE];
                psSel_ff <= pwdata[`SACC_CTRL_PS];
            end
            if (wr && paddr == `SACC_OFS_MUX)
            begin
                refReq_ff <= pwdata[`SACC_MUX_REF];
                leftAdj_ff <= pwdata[`SACC_MUX_LAR];
                chanReq_ff <= pwdata[`SACC_MUX_CH];
            end
            if (wr && paddr == `SACC_OFS_TRIG)
                trigSel_ff <= pwdata[`SACC_TRIG_SEL];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // prescaler and trigger
    assign psLimit = (`SACC_PS_BASE << psSel_ff) - 9'h001;
    assign tick = psCnt_ff == psLimit;
    assign freeRun = auto_ff && trigSel_ff == 3'h0;
    assign trigMux = (trigSel_ff == 3'h0) ? flag_ff : trigSrc[trigSel_ff];
    assign trigEdge = trigMux && !trigPrev_ff;
    // level alone never starts; busy swallows edges
    assign trigStart = enable_ff && auto_ff && !freeRun && trigEdge && !startBit_ff;
    assign swStart = wrCtrl && pwdata[`SACC_CTRL_ST] && pwdata[`SACC_CTRL_EN];

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            psCnt_ff <= 9'h000;
            trigPrev_ff <= 1'b0;
        end
        else
        begin
            trigPrev_ff <= trigMux;
            if (!enable_ff || trigStart || tick)
                psCnt_ff <= 9'h000;
            else
                psCnt_ff <= psCnt_ff + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // conversion sequencing
    assign total = first_ff ? `SACC_CYC_FIRST : `SACC_CYC_NORM;
    assign sampleAt = total - `SACC_SAMPLE_LEAD;
    assign bitPos = total - 5'h01 - cycCnt_ff;
    assign bitIdx = bitPos[3:0];
    assign sampleTick = state_ff == SACC_CONV && tick && cycCnt_ff == sampleAt;
    assign bitTick = state_ff == SACC_CONV && tick && cycCnt_ff > sampleAt
        && cycCnt_ff < total;
    assign done = state_ff == SACC_CONV && tick && cycCnt_ff == total;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            state_ff <= SACC_IDLE;
            cycCnt_ff <= 5'h00;
        end
        else if (!enable_ff)
            state_ff <= SACC_IDLE;
        else
        begin
            unique case (state_ff)
                SACC_IDLE:
                    if (startBit_ff)
                        state_ff <= SACC_WAIT;
                SACC_WAIT:
                    if (tick)
                    begin
                        state_ff <= SACC_CONV;
                        cycCnt_ff <= 5'h01;
                    end
                SACC_CONV:
                    if (done)
                        state_ff <= SACC_IDLE;
                    else if (tick)
                        cycCnt_ff <= cycCnt_ff + 5'h01;
                default:
                    state_ff <= SACC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        // enable and start may share one write, so start outranks the idle clear
        if (!rst_b)
            startBit_ff <= 1'b0;
        else if (swStart || trigStart)
            startBit_ff <= 1'b1;
        else if (!enable_ff)
            startBit_ff <= 1'b0;
        else if (done && !freeRun)
            startBit_ff <= 1'b0;
    end

    // extended first conversion after every enable
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            first_ff <= 1'b1;
        else if (!enable_ff)
            first_ff <= 1'b1;
        else if (done)
            first_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // flag, lock, result, interrupt
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            flag_ff <= 1'b0;
        else
            flag_ff <= done || (flag_ff && !(wrCtrl && pwdata[`SACC_CTRL_FL]));
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            lock_ff <= 1'b0;
        else if (rd && paddr == `SACC_OFS_RESLO)
            lock_ff <= 1'b1;
        else if (rd && paddr == `SACC_OFS_RESHI)
            lock_ff <= 1'b0;
    end

    // a locked completion drops its result
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            res_ff <= 10'h000;
        else if (done && !lock_ff)
            res_ff <= anaCtrl.dac;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            irqReq <= 1'b0;
        else
            irqReq <= flag_ff && irqEn_ff && gieIn;
    end

    ////////////////////////////////////////////////////////////////////
    // analog front end
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cmpMeta_ff <= 1'b0;
            cmpSync_ff <= 1'b0;
        end
        else
        begin
            cmpMeta_ff <= cmpIn;
            cmpSync_ff <= cmpMeta_ff;
        end
    end

    assign single = chanReq_ff <= `SACC_CH_SE_LAST || chanReq_ff >= `SACC_CH_BANDGAP;
    always_comb
    begin
        if (chanReq_ff[4:3] == `SACC_CH_GAIN_GRP)
            gainDec = chanReq_ff[1] ? SACC_G200 : SACC_G10;
        else
            gainDec = SACC_G1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            anaCtrl <= '0;
        else
        begin
            anaCtrl.powerOn <= enable_ff;
            anaCtrl.sample <= sampleTick;
            // selection frozen during a conversion
            if (enable_ff && state_ff != SACC_CONV)
            begin
                anaCtrl.refSel <= refReq_ff;
                anaCtrl.chanSel <= chanReq_ff;
                anaCtrl.bypass <= single;
                anaCtrl.gain <= gainDec;
            end
            if (sampleTick)
                anaCtrl.dac <= 10'h200;
            else if (bitTick)
            begin
                anaCtrl.dac[bitIdx] <= cmpSync_ff;
                if (bitIdx != 4'h0)
                    anaCtrl.dac[bitIdx - 4'h1] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence doneEvt;
        done;
    endsequence
    sequence restart;
        startBit_ff ##1 state_ff == SACC_WAIT;
    endsequence

    flag_set_a: assert property (doneEvt |=> flag_ff)
        else $error("flag not set after completion");
    start_held_a: assert property (state_ff == SACC_CONV |-> startBit_ff)
        else $error("start bit low during conversion");
    single_clear_a: assert property (doneEvt ##0 !freeRun |=> !startBit_ff)
        else $error("start bit not cleared");
    free_run_a: assert property (doneEvt ##0 freeRun |=> restart)
        else $error("free running did not restart");
    lock_hold_a: assert property (doneEvt ##0 lock_ff |=> $stable(res_ff))
        else $error("locked result changed");
    hi_unlock_a: assert property (rd && paddr == `SACC_OFS_RESHI |=> !lock_ff)
        else $error("high read left lock set");
    ps_off_a: assert property (!enable_ff |=> psCnt_ff == 9'h000)
        else $error("prescaler ran while disabled");
    trig_reset_a: assert property (trigStart |=> psCnt_ff == 9'h000 ##1 startBit_ff)
        else $error("trigger did not restart");
    edge_ignore_a: assert property (trigEdge && startBit_ff && !tick && enable_ff
        |=> psCnt_ff == $past(psCnt_ff) + 9'h001)
        else $error("busy trigger reset prescaler");
    chan_hold_a: assert property (state_ff == SACC_CONV ##1 state_ff == SACC_CONV
        |-> $stable(anaCtrl.chanSel))
        else $error("channel changed mid conversion");
    irq_a: assert property (flag_ff && irqEn_ff && gieIn |=> irqReq)
        else $error("interrupt not raised");

endmodule

// file: hw/sacc_defs.svh
// Purpose: offsets, field positions, reset values and counts
// Assumes: 32-bit apb, byte addresses, one register per word
// Notes: definitions only
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH

// register byte offsets
`define SACC_OFS_CTRL 8'h00
`define SACC_OFS_MUX 8'h04
`define SACC_OFS_TRIG 8'h08
`define SACC_OFS_RESLO 8'h0c
`define SACC_OFS_RESHI 8'h10

// control/status fields
`define SACC_CTRL_EN 7
`define SACC_CTRL_ST 6
`define SACC_CTRL_AT 5
`define SACC_CTRL_FL 4
`define SACC_CTRL_IE 3
`define SACC_CTRL_PS 2:0

// multiplexer select fields
`define SACC_MUX_REF 7:6
`define SACC_MUX_LAR 5
`define SACC_MUX_CH 4:0
`define SACC_TRIG_SEL 7:5

// reset values
`define SACC_PS_RST 3'h0
`define SACC_REF_RST 2'h0
`define SACC_CH_RST 5'h00
`define SACC_TRIG_RST 3'h0

// converter cycle counts
`define SACC_CYC_NORM 5'h0d
`define SACC_CYC_FIRST 5'h19
`define SACC_SAMPLE_LEAD 5'h0b
`define SACC_PS_BASE 9'h004

// channel decode
`define SACC_CH_SE_LAST 5'h07
`define SACC_CH_BANDGAP 5'h1e
`define SACC_CH_GAIN_GRP 2'h1

`endif

// file: hw/sacc_pkg.sv
// Purpose: shared types of the converter control block
// Assumes: nothing
// Notes: constants live in sacc_defs.svh
package sacc_pkg;

    typedef enum logic [1:0] {
        SACC_IDLE = 2'b00,
        SACC_WAIT = 2'b01,
        SACC_CONV = 2'b10
    } sacc_state_t;

    typedef enum logic [1:0] {
        SACC_G1 = 2'h0,
        SACC_G10 = 2'h1,
        SACC_G200 = 2'h2
    } sacc_gain_t;

    typedef struct packed {
        logic powerOn;
        logic sample;
        logic [9:0] dac;
        logic [1:0] refSel;
        logic [4:0] chanSel;
        logic bypass;
        sacc_gain_t gain;
    } sacc_ana_t;

endpackage

// file: verification/sacc_ana_model.sv
// Purpose: ideal analog core facing the converter control
// Assumes: comparator settles within one clock of a new trial code
// Notes: unpowered core gives a wandering output, never a held one
`timescale 1ns/1ns

module sacc_ana_model
(
    // clock
    input wire logic clk_sys,
    // level under test
    input wire logic [9:0] vin,
    // control side
    input wire sacc_pkg::sacc_ana_t anaCtrl,
    output logic cmpIn
);
    import sacc_pkg::*;

    logic toggle_ff = 1'b0;

    always @(posedge clk_sys)
    begin
        toggle_ff <= ~toggle_ff;
    end

    // ideal compare against the trial code, so the result equals vin
    assign cmpIn = anaCtrl.powerOn ? (vin >= anaCtrl.dac) : toggle_ff;
endmodule

// file: verification/sacc_conv_ctrl_tb.sv
// Purpose: self-checking bench of the converter control
// Assumes: prescale select 0, so four clocks per converter cycle
// Notes: result model follows the read-order lock
`timescale 1ns/1ns
`include "sacc_defs.svh"

module sacc_conv_ctrl_tb;
    import sacc_pkg::*;

    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic gieIn = 1'b0;
    logic [7:0] trigSrc = 8'h00;
    logic [9:0] vinR = 10'h000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irqReq;
    logic cmpIn;
    sacc_ana_t anaCtrl;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int compares = 0;
    int resM = 0;
    int cyc = 0;
    bit lockM = 1'b0;
    logic [4:0] chTab [8] = '{5'h00, 5'h07, 5'h08, 5'h0a, 5'h0d, 5'h0e, 5'h10, 5'h1e};

    sacc_conv_ctrl sacc_conv_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gieIn(gieIn), .trigSrc(trigSrc),
        .irqReq(irqReq), .cmpIn(cmpIn), .anaCtrl(anaCtrl));

    sacc_ana_model sacc_ana_model_inst (.clk_sys(clk_sys), .vin(vinR), .anaCtrl(anaCtrl),
        .cmpIn(cmpIn));

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            chk("pready", 32'h0, 32'h1);
    endtask

    function automatic logic [31:0] fmt(input int r, input bit lar, input bit hi);
        logic [9:0] v;
        v = r[9:0];
        if (lar)
            return hi ? {24'h0, v[9:2]} : {24'h0, v[1:0], 6'h00};
        return hi ? {30'h0, v[9:8]} : {24'h0, v[7:0]};
    endfunction

    task automatic rdres(input bit lar);
        apb(1'b0, `SACC_OFS_RESLO, 32'h0);
        chk("reslo", rd, fmt(resM, lar, 1'b0));
        apb(1'b0, `SACC_OFS_RESHI, 32'h0);
        chk("reshi", rd, fmt(resM, lar, 1'b1));
    endtask

    task automatic waitDone();
        int n;
        n = 0;
        apb(1'b0, `SACC_OFS_CTRL, 32'h0);
        chk("busy", 32'(rd[`SACC_CTRL_ST]), 32'h1);
        do apb(1'b0, `SACC_OFS_CTRL, 32'h0); while (rd[`SACC_CTRL_ST] === 1'b1 && ++n < 100);
        chk("start", 32'(rd[`SACC_CTRL_ST]), 32'h0);
        chk("flag", 32'(rd[`SACC_CTRL_FL]), 32'h1);
        // a locked pair keeps the older result
        if (!lockM)
            resM = vinR;
        @(posedge clk_sys);
        chk("irq", 32'(irqReq), 32'(gieIn));
    endtask

    task automatic conv(input logic [9:0] v);
        vinR <= v;
        // flag cleared with the start, so a missing set is seen
        apb(1'b1, `SACC_OFS_CTRL, 32'hd8);
        waitDone();
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #300000;
        err_count++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(50116));
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        apb(1'b0, `SACC_OFS_CTRL, 32'h0);
        chk("ctrl rst", rd, 32'h0);
        apb(1'b0, `SACC_OFS_MUX, 32'h0);
        chk("mux rst", rd, 32'h0);
        apb(1'b0, `SACC_OFS_TRIG, 32'h0);
        chk("trig rst", rd, 32'h0);
        chk("ana rst", 32'(anaCtrl), 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'(er), 32'h1);
        chk("unmapped data", rd, 32'h0);
        // channel decode while enabled and idle
        apb(1'b1, `SACC_OFS_CTRL, 32'h80);
        foreach (chTab[k])
        begin
            apb(1'b1, `SACC_OFS_MUX, {24'h0, 2'b01, 1'b0, chTab[k]});
            repeat (2) @(posedge clk_sys);
            chk("chan", 32'(anaCtrl.chanSel), 32'(chTab[k]));
            chk("ref", 32'(anaCtrl.refSel), 32'h1);
            chk("bypass", 32'(anaCtrl.bypass), 32'(chTab[k] <= 5'h07 || chTab[k] >= 5'h1e));
            if (chTab[k] > 5'h07 && chTab[k] < 5'h1e)
                chk("gain", 32'(anaCtrl.gain),
                    (chTab[k] <= 5'h0f) ? (chTab[k][1] ? 32'h2 : 32'h1) : 32'h0);
        end
        // selection change in mid-conversion waits for its end
        apb(1'b1, `SACC_OFS_MUX, 32'h03);
        vinR <= 10'($urandom);
        apb(1'b1, `SACC_OFS_CTRL, 32'hd8);
        // two converter cycles later the conversion has surely begun
        repeat (8) @(posedge clk_sys);
        apb(1'b1, `SACC_OFS_MUX, 32'h05);
        repeat (2) @(posedge clk_sys);
        chk("chan held", 32'(anaCtrl.chanSel), 32'h3);
        waitDone();
        chk("chan new", 32'(anaCtrl.chanSel), 32'h5);
        rdres(1'b0);
        for (int i = 0; i < 4; i++)
        begin
            gieIn <= 1'($urandom);
            apb(1'b1, `SACC_OFS_MUX, {26'h0, i[0], 5'h00});
            conv(10'($urandom));
            rdres(i[0]);
        end
        gieIn <= 1'b1;
        apb(1'b1, `SACC_OFS_CTRL, 32'h98);
        repeat (2) @(posedge clk_sys);
        chk("irq clr", 32'(irqReq), 32'h0);
        // low read locks, completion in between is lost
        conv(10'($urandom));
        apb(1'b0, `SACC_OFS_RESLO, 32'h0);
        chk("lock lo", rd, fmt(resM, 1'b1, 1'b0));
        lockM = 1'b1;
        conv(~vinR);
        apb(1'b0, `SACC_OFS_RESHI, 32'h0);
        chk("lock hi", rd, fmt(resM, 1'b1, 1'b1));
        lockM = 1'b0;
        conv(10'($urandom));
        rdres(1'b1);
        // auto trigger on source 1, others raised and held
        apb(1'b1, `SACC_OFS_TRIG, 32'h20);
        apb(1'b1, `SACC_OFS_CTRL, 32'hb8);
        trigSrc <= 8'hfc;
        repeat (30) @(posedge clk_sys);
        apb(1'b0, `SACC_OFS_CTRL, 32'h0);
        chk("other src", 32'(rd[`SACC_CTRL_ST]), 32'h0);
        vinR <= 10'($urandom);
        trigSrc <= 8'hfe;
        waitDone();
        rdres(1'b1);
        repeat (150) @(posedge clk_sys);
        apb(1'b0, `SACC_OFS_CTRL, 32'h0);
        chk("held trig", 32'(rd[`SACC_CTRL_ST]), 32'h0);
        // software clears the source before the next edge
        trigSrc <= 8'h00;
        repeat (2) @(posedge clk_sys);
        trigSrc <= 8'h02;
        vinR <= 10'($urandom);
        waitDone();
        rdres(1'b1);
        // free running from the completion flag
        apb(1'b1, `SACC_OFS_TRIG, 32'h0);
        // flag cleared here, so only a free-run completion sets it again
        apb(1'b1, `SACC_OFS_CTRL, 32'hf8);
        repeat (300) @(posedge clk_sys);
        apb(1'b0, `SACC_OFS_CTRL, 32'h0);
        chk("free start", 32'(rd[`SACC_CTRL_ST]), 32'h1);
        chk("free flag", 32'(rd[`SACC_CTRL_FL]), 32'h1);
        // disable before sleep
        apb(1'b1, `SACC_OFS_CTRL, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("power off", 32'(anaCtrl.powerOn), 32'h0);
        // enable and start in one write; the first conversion is the long one
        vinR <= 10'($urandom);
        apb(1'b1, `SACC_OFS_CTRL, 32'hd8);
        cyc = 0;
        while (irqReq !== 1'b1 && cyc < 400)
        begin
            @(posedge clk_sys);
            cyc++;
        end
        chk("first len", 32'(cyc >= 100 && cyc <= 112), 32'h1);
        resM = vinR;
        rdres(1'b1);
        wrap_up();
    end
endmodule
